// ==== arx_cfg.svh ====
// Constants of the dual line receiver block: offsets, fields, timing.
// Assumes a 100 MHz reference clock and a 32-bit classic Wishbone bus.
`ifndef ARX_CFG_SVH
`define ARX_CFG_SVH
// ==========================================
// Register byte offsets
`define ARX_ADR_CTRL     8'h00
`define ARX_ADR_LABEL    8'h04
`define ARX_ADR_STATUS   8'h08
`define ARX_ADR_IRQ_STAT 8'h0c
`define ARX_ADR_IRQ_MASK 8'h10
`define ARX_ADR_RX1_LO   8'h14
`define ARX_ADR_RX1_HI   8'h18
`define ARX_ADR_RX_STEP  8'h08
// ==========================================
// Control fields and reset values
`define ARX_CTL_W        11
`define ARX_CTL_FMT      0
`define ARX_CTL_LBL      1
`define ARX_CTL_DEC      3
`define ARX_CTL_SPD      9
`define ARX_CTL_RST      11'h000
`define ARX_LABEL_RST    16'h0000
`define ARX_MASK_RST     6'h00
`define ARX_FIFO_FULL    6'h20
`define ARX_FIFO_HALF    6'h10
// ==========================================
// Timing
`define ARX_REF_PERIOD_NS 10
`define ARX_SAMPLE_NS     1000
`define ARX_DIV_M1  7'((`ARX_SAMPLE_NS + `ARX_REF_PERIOD_NS - 1) / `ARX_REF_PERIOD_NS - 1)
`define ARX_SLOW_M1       3'h7
`define ARX_SPACE_MIN     4'h8
`define ARX_SPACE_MAX     4'hc
`define ARX_NULL_WIN      4'ha
`define ARX_GAP_M1        4'h9
`define ARX_GAP_COUNT_M1  2'h2
`define ARX_LAST_BIT      5'h1f
`endif

// ==== arx_pkg.sv ====
// Types shared by the dual line receiver block.
// Assumes nothing beyond a SystemVerilog compiler.
package arx_pkg;
  typedef enum logic [1:0] {
    ST_GAP   = 2'b00,
    ST_IDLE  = 2'b01,
    ST_NULL  = 2'b10,
    ST_SPACE = 2'b11
  } arx_rx_state_t;
endpackage

// ==== arx_fifo_mem.sv ====
// 32 x 32 word store for one receiver FIFO, registered read data.
// Assumes the caller keeps the pointers.
module arx_fifo_mem (
  input  wire logic        ref_clk_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  waddr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [4:0]  raddr_i,
  output logic      [31:0] rdata_o
);
  logic [31:0] mem [32];

  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule

// ==== arx_line_decoder.sv ====
// Serial word assembly for one receiver from its comparator outputs.
// Assumes a one-cycle sample tick at 1 MHz; line inputs are asynchronous.
`include "arx_cfg.svh"
module arx_line_decoder
  import arx_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        sample_tick_i,
  input  wire logic        low_speed_i,
  input  wire logic        line_one_i,
  input  wire logic        line_zero_i,
  output logic             end_of_word_strobe_o,
  output logic             err_o,
  output logic      [31:0] word_o
);
  // ==========================================
  // Sampling
  logic [1:0]    one_sync;
  logic [1:0]    zero_sync;
  logic [2:0]    slow_cnt;
  logic [9:0]    one_sr;
  logic [9:0]    zero_sr;
  logic [9:0]    null_sr;
  logic          smp;
  logic          pulse_one;
  logic          pulse_any;
  logic          null3;
  logic          gap_null;
  logic          bad_level;
  arx_rx_state_t state;
  logic [3:0]    spc;
  logic [3:0]    next_spc;
  logic [4:0]    bits;
  logic [3:0]    gtick;
  logic [1:0]    gcnt;
  logic [31:0]   shreg;
  logic [31:0]   next_word;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      one_sync  <= 2'h0;
      zero_sync <= 2'h0;
      slow_cnt  <= 3'h0;
    end else begin
      one_sync  <= {one_sync[0], line_one_i};
      zero_sync <= {zero_sync[0], line_zero_i};
      if (sample_tick_i) begin
        slow_cnt <= slow_cnt + 3'h1;
      end
    end
  end

  // Low speed takes every eighth tick, so one window fits both rates
  assign smp = sample_tick_i && (!low_speed_i || slow_cnt == `ARX_SLOW_M1);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      one_sr  <= 10'h000;
      zero_sr <= 10'h000;
      null_sr <= 10'h000;
    end else if (smp) begin
      one_sr  <= {one_sr[8:0], one_sync[1]};
      zero_sr <= {zero_sr[8:0], zero_sync[1]};
      null_sr <= {null_sr[8:0], !one_sync[1] && !zero_sync[1]};
    end
  end

  assign pulse_one = one_sr[2:0] == 3'h7;
  assign pulse_any = pulse_one || zero_sr[2:0] == 3'h7;
  assign null3     = null_sr[2:0] == 3'h7;
  assign gap_null  = null3 && null_sr[9:7] == 3'h7;
  assign bad_level = one_sync[1] && zero_sync[1];
  assign next_spc  = spc + 4'h1;
  assign next_word = {pulse_one, shreg[31:1]};

  // ==========================================
  // Bit and gap sequencing
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= ST_GAP;
      spc   <= 4'h0;
      bits  <= 5'h0;
      gtick <= 4'h0;
      gcnt  <= 2'h0;
      shreg <= 32'h0;
      word_o <= 32'h0;
      end_of_word_strobe_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      end_of_word_strobe_o <= 1'b0;
      err_o <= 1'b0;
      if (smp) begin
        case (state)
          ST_GAP: begin
            if (gtick == `ARX_GAP_M1) begin
              gtick <= 4'h0;
              if (gap_null && gcnt == `ARX_GAP_COUNT_M1) begin
                gcnt  <= 2'h0;
                state <= ST_IDLE;
              end else if (gap_null) begin
                gcnt <= gcnt + 2'h1;
              end
            end else begin
              gtick <= gtick + 4'h1;
            end
          end
          ST_IDLE: begin
            if (pulse_any && !bad_level) begin
              shreg <= next_word;
              bits  <= 5'h1;
              spc   <= 4'h0;
              state <= ST_NULL;
            end
          end
          ST_NULL: begin
            spc <= next_spc;
            if (bad_level || next_spc >= `ARX_NULL_WIN) begin
              state <= ST_GAP;
              err_o <= 1'b1;
            end else if (null3) begin
              state <= ST_SPACE;
            end
          end
          default: begin
            spc <= next_spc;
            if (bad_level || next_spc > `ARX_SPACE_MAX ||
                (pulse_any && next_spc < `ARX_SPACE_MIN)) begin
              state <= ST_GAP;
              err_o <= 1'b1;
            end else if (pulse_any && bits == `ARX_LAST_BIT) begin
              word_o <= {~^next_word, next_word[30:0]};
              end_of_word_strobe_o <= 1'b1;
              state <= ST_GAP;
            end else if (pulse_any) begin
              shreg <= next_word;
              bits  <= bits + 5'h1;
              spc   <= 4'h0;
              state <= ST_NULL;
            end
          end
        endcase
        if (state != ST_GAP && state != ST_IDLE && (bad_level ||
            next_spc > `ARX_SPACE_MAX)) begin
          gtick <= 4'h0;
          gcnt  <= 2'h0;
        end
      end
    end
  end

  // ==========================================
  // Checks
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  chk_gap_after_word: assert property (
    end_of_word_strobe_o |-> (state == ST_GAP && gcnt == 2'h0) [*8])
    else $error("receiver left the gap too early");
  chk_abandon_word: assert property (
    err_o |-> state == ST_GAP && !end_of_word_strobe_o)
    else $error("violation did not abandon the word");
  chk_three_samples: assert property (
    state == ST_NULL && $past(state) == ST_IDLE |-> $past(pulse_any))
    else $error("bit taken without three equal samples");
endmodule

// ==== arx_dual_receiver.sv ====
// Receive logic of a dual serial avionics terminal with host register bus.
// Assumes classic Wishbone master on ref_clk_i; line inputs asynchronous.
//
// Notes on behaviour
// - Format clear: low half 13..9,31,30,parity,label; high half bits 29..14.
// - Format set: low half 16..9 and label; high half parity then 31..17.
// - Ten-bit sample registers; a level counts after three equal samples.
// - A data pulse must be followed by a Null within one bit time.
// - Gap Null needs three Nulls in both upper and lower sample bits.
// - Consecutive data bits start 8 to 12 samples apart.
// - Gap timer tests Null every 10 samples, three hits re-enable reception.
// - Stored bit 32 is a parity flag: 0 odd, 1 even.
// - End-of-word strobe after 32 valid bits starts filtering and loading.
// - Load only when label and bit 9/10 checks pass or are off.
// - Data ready low from first load until the high half of the last word is read, FIFO empty.
// - Each receiver answers only its own read enable (address here).
// - FIFO holds 32 words; full output low while all are occupied.
// - Word arriving at full FIFO overwrites the 32nd position.
// - Half-full output low while FIFO holds 16 or more words.
// - Status word shows ready, half-full, full inverted from the pins.
// - Label bits 0..7 compare with received bits 1..8, any format.
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`include "arx_cfg.svh"
module arx_dual_receiver
  import arx_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx1_line_one_i,
  input  wire logic        rx1_line_zero_i,
  input  wire logic        rx2_line_one_i,
  input  wire logic        rx2_line_zero_i,
  output logic             rx1_data_ready_n_o,
  output logic             rx2_data_ready_n_o,
  output logic             rx1_fifo_full_n_o,
  output logic             rx2_fifo_full_n_o,
  output logic             rx1_half_full_n_o,
  output logic             rx2_half_full_n_o,
  output logic             irq_o
);
  // ==========================================
  // Declarations
  logic [`ARX_CTL_W-1:0] ctrl;
  logic [15:0]           labels;
  logic [5:0]            irq_mask;
  logic [5:0]            irq_stat;
  logic [5:0]            next_irq_stat;
  logic [5:0]            irq_ev;
  logic [5:0]            status;
  logic [31:0]           next_rdata;
  logic [31:0]           wmask;
  logic [6:0]            tick_cnt;
  logic                  sample_tick;
  logic                  busy;
  logic                  bus_rd;
  logic                  bus_wr;
  logic                  fmt;
  logic [1:0]            line_one;
  logic [1:0]            line_zero;
  logic [1:0]            eow;
  logic [1:0]            err;
  logic [1:0]            accept;
  logic [1:0]            load;
  logic [1:0]            ovw;
  logic [1:0]            pop;
  logic [1:0]            dr_n;
  logic [1:0]            ff_n;
  logic [1:0]            hf_n;
  logic [31:0]           word [2];
  logic [31:0]           q [2];
  logic [4:0]            wptr [2];
  logic [4:0]            rptr [2];
  logic [5:0]            cnt [2];
  logic [5:0]            next_cnt [2];

  // Host half-word mapping of a stored word
  function automatic logic [15:0] arx_half(input logic [31:0] w,
                                           input logic fs,
                                           input logic hi);
    logic [15:0] r;
    r = 16'h0000;
    if (!fs && !hi) begin
      r = {w[12:8], w[30:29], w[31], w[7:0]};
    end else if (!fs) begin
      r = w[28:13];
    end else if (!hi) begin
      r = {w[15:8], w[7:0]};
    end else begin
      r = {w[31], w[30:16]};
    end
    return r;
  endfunction

  assign fmt       = ctrl[`ARX_CTL_FMT];
  assign line_one  = {rx2_line_one_i, rx1_line_one_i};
  assign line_zero = {rx2_line_zero_i, rx1_line_zero_i};

  // ==========================================
  // Sample tick, shared by both receivers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tick_cnt    <= 7'h00;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= tick_cnt == `ARX_DIV_M1;
      tick_cnt    <= (tick_cnt == `ARX_DIV_M1) ? 7'h00 : tick_cnt + 7'h01;
    end
  end

  // ==========================================
  // Receivers and FIFOs
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_rx
      logic [4:0] waddr;

      arx_line_decoder u_dec (
        .ref_clk_i            (ref_clk_i),
        .srst_i               (srst_i),
        .sample_tick_i        (sample_tick),
        .low_speed_i          (ctrl[`ARX_CTL_SPD + i]),
        .line_one_i           (line_one[i]),
        .line_zero_i          (line_zero[i]),
        .end_of_word_strobe_o (eow[i]),
        .err_o                (err[i]),
        .word_o               (word[i])
      );

      assign accept[i] = (!ctrl[`ARX_CTL_LBL + i] ||
                          word[i][7:0] == labels[8*i +: 8]) &&
                         (!ctrl[`ARX_CTL_DEC + 3*i] ||
                          word[i][9:8] == {ctrl[`ARX_CTL_DEC + 3*i + 2],
                                           ctrl[`ARX_CTL_DEC + 3*i + 1]});
      assign load[i] = eow[i] && accept[i];
      assign ovw[i]  = load[i] && cnt[i] == `ARX_FIFO_FULL;
      // Only the high half pops; the low half may be reread freely
      assign pop[i]  = bus_rd && cnt[i] != 6'h00 &&
                       wb_adr_i == `ARX_ADR_RX1_HI + 8'(i) * `ARX_ADR_RX_STEP;
      // Full FIFO rewrites the newest slot instead of dropping the word
      assign waddr   = ovw[i] ? wptr[i] - 5'h01 : wptr[i];
      assign next_cnt[i] = cnt[i] + {5'h00, load[i] && !ovw[i]} - {5'h00, pop[i]};

      arx_fifo_mem u_mem (
        .ref_clk_i (ref_clk_i),
        .we_i      (load[i]),
        .waddr_i   (waddr),
        .wdata_i   (word[i]),
        .raddr_i   (rptr[i]),
        .rdata_o   (q[i])
      );

      always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
          wptr[i] <= 5'h00;
          rptr[i] <= 5'h00;
          cnt[i]  <= 6'h00;
        end else begin
          if (load[i] && !ovw[i]) begin
            wptr[i] <= wptr[i] + 5'h01;
          end
          if (pop[i]) begin
            rptr[i] <= rptr[i] + 5'h01;
          end
          cnt[i] <= next_cnt[i];
        end
      end

      always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
          dr_n[i] <= 1'b1;
          ff_n[i] <= 1'b1;
          hf_n[i] <= 1'b1;
        end else begin
          dr_n[i] <= next_cnt[i] == 6'h00;
          ff_n[i] <= next_cnt[i] != `ARX_FIFO_FULL;
          hf_n[i] <= next_cnt[i] < `ARX_FIFO_HALF;
        end
      end

      chk_full_pin: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        ff_n[i] == (cnt[i] != `ARX_FIFO_FULL))
        else $error("full output disagrees with word count");
      chk_half_pin: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        hf_n[i] == (cnt[i] < `ARX_FIFO_HALF))
        else $error("half-full output disagrees with word count");
      chk_ready_low: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        load[i] |=> !dr_n[i] && cnt[i] != 6'h00)
        else $error("data ready not low after a load");
      chk_overwrite_last: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        ovw[i] && !pop[i] |=> cnt[i] == `ARX_FIFO_FULL && $stable(wptr[i]))
        else $error("full FIFO grew or moved on an overwrite");
      chk_filter_drop: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        eow[i] && !accept[i] && !pop[i] |=> $stable(cnt[i]) && $stable(wptr[i]))
        else $error("filtered word reached the FIFO");
      chk_ready_held: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !dr_n[i] && !(pop[i] && cnt[i] == 6'h01) |=> !dr_n[i])
        else $error("data ready rose with words still stored");
      chk_pop_step: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        pop[i] |=> rptr[i] == $past(rptr[i]) + 5'h01)
        else $error("high half read did not advance the FIFO");
      cov_overwrite: cover property (
        @(posedge ref_clk_i) disable iff (srst_i) ovw[i]);
      cov_drop: cover property (
        @(posedge ref_clk_i) disable iff (srst_i) eow[i] && !accept[i]);
    end
  endgenerate

  assign rx1_data_ready_n_o = dr_n[0];
  assign rx2_data_ready_n_o = dr_n[1];
  assign rx1_fifo_full_n_o  = ff_n[0];
  assign rx2_fifo_full_n_o  = ff_n[1];
  assign rx1_half_full_n_o  = hf_n[0];
  assign rx2_half_full_n_o  = hf_n[1];

  // Status bits mirror the pin flops so both views always agree
  assign status = {~ff_n[1], ~hf_n[1], ~dr_n[1],
                   ~ff_n[0], ~hf_n[0], ~dr_n[0]};

  // ==========================================
  // Wishbone slave
  // Two wait states: register the request, decode in the busy cycle, answer on the next edge
  assign bus_rd = busy && !wb_we_i;
  assign bus_wr = busy && wb_we_i;
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      busy     <= 1'b0;
      wb_ack_o <= 1'b0;
    end else begin
      busy     <= wb_cyc_i && wb_stb_i && !busy && !wb_ack_o;
      wb_ack_o <= busy;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (wb_adr_i == `ARX_ADR_CTRL) begin
      next_rdata = {21'h0, ctrl};
    end else if (wb_adr_i == `ARX_ADR_LABEL) begin
      next_rdata = {16'h0000, labels};
    end else if (wb_adr_i == `ARX_ADR_STATUS) begin
      next_rdata = {26'h0, status};
    end else if (wb_adr_i == `ARX_ADR_IRQ_STAT) begin
      next_rdata = {26'h0, irq_stat};
    end else if (wb_adr_i == `ARX_ADR_IRQ_MASK) begin
      next_rdata = {26'h0, irq_mask};
    end else if (wb_adr_i == `ARX_ADR_RX1_LO) begin
      next_rdata = {16'h0000, arx_half(q[0], fmt, 1'b0)};
    end else if (wb_adr_i == `ARX_ADR_RX1_HI) begin
      next_rdata = {16'h0000, arx_half(q[0], fmt, 1'b1)};
    end else if (wb_adr_i == `ARX_ADR_RX1_LO + `ARX_ADR_RX_STEP) begin
      next_rdata = {16'h0000, arx_half(q[1], fmt, 1'b0)};
    end else if (wb_adr_i == `ARX_ADR_RX1_HI + `ARX_ADR_RX_STEP) begin
      next_rdata = {16'h0000, arx_half(q[1], fmt, 1'b1)};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_rd) begin
      wb_dat_o <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctrl     <= `ARX_CTL_RST;
      labels   <= `ARX_LABEL_RST;
      irq_mask <= `ARX_MASK_RST;
    end else if (bus_wr) begin
      if (wb_adr_i == `ARX_ADR_CTRL) begin
        ctrl <= (ctrl & ~wmask[`ARX_CTL_W-1:0]) | (wb_dat_i[`ARX_CTL_W-1:0] &
                wmask[`ARX_CTL_W-1:0]);
      end else if (wb_adr_i == `ARX_ADR_LABEL) begin
        labels <= (labels & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end else if (wb_adr_i == `ARX_ADR_IRQ_MASK) begin
        irq_mask <= (irq_mask & ~wmask[5:0]) | (wb_dat_i[5:0] & wmask[5:0]);
      end
    end
  end

  // ==========================================
  // Interrupts
  // A new event in the clearing read's cycle stays set
  assign irq_ev = {err, ovw, load};
  assign next_irq_stat = ((bus_rd && wb_adr_i == `ARX_ADR_IRQ_STAT) ?
                          6'h00 : irq_stat) | irq_ev;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq_stat <= 6'h00;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_o    <= |(next_irq_stat & irq_mask);
    end
  end

  // ==========================================
  // Checks
  chk_high_half_map: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    bus_rd && fmt && wb_adr_i == `ARX_ADR_RX1_HI + `ARX_ADR_RX_STEP |=>
      wb_ack_o && wb_dat_o[15:0] == {$past(q[1][31]), $past(q[1][30:16])})
    else $error("high half mapping wrong with format set");
  chk_low_half_map: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    bus_rd && !fmt && wb_adr_i == `ARX_ADR_RX1_LO |=>
      wb_dat_o[8] == $past(q[0][31]) && wb_dat_o[10:9] == $past(q[0][30:29]))
    else $error("low half mapping wrong with format clear");
  chk_ack_pulse: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held for more than one cycle");
  // Set beats clear, so an event in the clearing read survives it
  chk_irq_sticky: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    irq_ev != 6'h00 |=> (irq_stat & $past(irq_ev)) == $past(irq_ev))
    else $error("interrupt event lost");
  cov_format_set: cover property (
    @(posedge ref_clk_i) disable iff (srst_i)
    bus_rd && fmt);
  cov_irq_clear: cover property (
    @(posedge ref_clk_i) disable iff (srst_i)
    bus_rd && wb_adr_i == `ARX_ADR_IRQ_STAT && irq_stat != 6'h00);
  cov_word_read: cover property (
    @(posedge ref_clk_i) disable iff (srst_i)
    pop[0] ##[1:40] pop[1]);
endmodule

// ==== arx_line_model.sv ====
// Far-side model: one serial transmitter feeding comparator outputs.
// Assumes a 100 MHz clock; one sample is 100 clocks, high speed only.
module arx_line_model (
  input  wire logic        ref_clk_i,
  input  wire logic        go_i,
  input  wire logic [31:0] word_i,
  output logic             one_o,
  output logic             zero_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] w;
  // ==========================================
  // Word transmission
  initial begin
    one_o = 1'b0;
    zero_o = 1'b0;
    forever begin
      @(posedge ref_clk_i);
      if (go_i) begin
        w = word_i;
        // Bit 1 first, five samples level then five Null
        for (int i = 0; i < 32; i++) begin
          one_o <= w[i];
          zero_o <= !w[i];
          repeat (500) @(posedge ref_clk_i);
          one_o <= 1'b0;
          zero_o <= 1'b0;
          repeat (500) @(posedge ref_clk_i);
        end
      end
    end
  end
endmodule

// ==== test_arinc429_dual_receiver_logic.sv ====
// Bench for the dual receiver: two line models and a Wishbone host.
// Assumes the register map of arx_cfg.svh and a 100 MHz clock.
`include "arx_cfg.svh"
module test_arinc429_dual_receiver_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i = 0, srst_i = 1, cyc = 0, stb = 0, wem = 0, go = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, q, w1, w2, wb_dat_o;
  logic        wb_ack_o, o1, z1, o2, z2, irq_o;
  logic        dr1_n, dr2_n, ff1_n, ff2_n, hf1_n, hf2_n;
  int          seed, n_fail = 0, comparisons = 0;

  arx_dual_receiver DUT (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(wem), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx1_line_one_i(o1), .rx1_line_zero_i(z1),
    .rx2_line_one_i(o2), .rx2_line_zero_i(z2), .rx1_data_ready_n_o(dr1_n),
    .rx2_data_ready_n_o(dr2_n), .rx1_fifo_full_n_o(ff1_n), .rx2_fifo_full_n_o(ff2_n),
    .rx1_half_full_n_o(hf1_n), .rx2_half_full_n_o(hf2_n), .irq_o(irq_o));
  arx_line_model u_line1 (.ref_clk_i(ref_clk_i), .go_i(go), .word_i(w1), .one_o(o1),
    .zero_o(z1));
  arx_line_model u_line2 (.ref_clk_i(ref_clk_i), .go_i(go), .word_i(w2), .one_o(o2),
    .zero_o(z2));

  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // ==========================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Host side: low half first, then high half pops the word
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    wem <= we;
    adr <= a;
    dat <= d;
    @(posedge ref_clk_i);
    while (wb_ack_o !== 1'b1) begin
      @(posedge ref_clk_i);
    end
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  function automatic logic [15:0] half(input logic [31:0] w, input logic f, input logic h);
    logic p;
    p = ~^w;
    case ({f, h})
      2'b00: half = {w[12:8], w[30:29], p, w[7:0]};
      2'b01: half = w[28:13];
      2'b10: half = w[15:0];
      default: half = {p, w[30:16]};
    endcase
  endfunction
  // Gap settles first, then both lines send and we wait for a load event
  task automatic send();
    int n;
    n = 0;
    repeat (5000) @(posedge ref_clk_i);
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    while (irq_o !== 1'b1 && n < 40000) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (irq_o !== 1'b1) begin
      n_fail++;
    end
    repeat (700) @(posedge ref_clk_i);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  initial begin
    seed = 96;
    w1 = $random(seed);
    w2 = $random(seed);
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    wb(1'b1, `ARX_ADR_CTRL, 32'h4, q);
    wb(1'b1, `ARX_ADR_LABEL, {16'h0, ~w2[7:0], w1[7:0]}, q);
    wb(1'b1, `ARX_ADR_IRQ_MASK, 32'h3, q);
    wb(1'b0, 8'h3c, 32'h0, q);
    chk("unmapped", q, 32'h0);
    send();
    chk("dr1_n", dr1_n, 1'b0);
    chk("dr2_n", dr2_n, 1'b1);
    wb(1'b0, `ARX_ADR_STATUS, 32'h0, q);
    chk("status", q, 32'h1);
    wb(1'b0, `ARX_ADR_IRQ_STAT, 32'h0, q);
    chk("irq stat", q, 32'h1);
    chk("irq", irq_o, 1'b0);
    wb(1'b0, `ARX_ADR_RX1_LO, 32'h0, q);
    chk("rx1 lo", q, {16'h0, half(w1, 1'b0, 1'b0)});
    chk("dr1_n lo", dr1_n, 1'b0);
    wb(1'b0, `ARX_ADR_RX1_HI, 32'h0, q);
    chk("rx1 hi", q, {16'h0, half(w1, 1'b0, 1'b1)});
    chk("dr1_n hi", dr1_n, 1'b1);
    w1 = $random(seed);
    w2 = $random(seed);
    wb(1'b1, `ARX_ADR_CTRL, {23'h0, w2[9], w2[8], 1'b1, 6'h0d} | {26'h0, w1[9], ~w1[8], 4'h0}, q);
    wb(1'b1, `ARX_ADR_LABEL, {16'h0, w2[7:0], w1[7:0]}, q);
    send();
    chk("dr1_n b", dr1_n, 1'b1);
    chk("dr2_n b", dr2_n, 1'b0);
    wb(1'b0, `ARX_ADR_IRQ_STAT, 32'h0, q);
    chk("irq stat b", q, 32'h2);
    wb(1'b0, `ARX_ADR_RX1_LO + `ARX_ADR_RX_STEP, 32'h0, q);
    chk("rx2 lo", q, {16'h0, half(w2, 1'b1, 1'b0)});
    wb(1'b0, `ARX_ADR_RX1_HI + `ARX_ADR_RX_STEP, 32'h0, q);
    chk("rx2 hi", q, {16'h0, half(w2, 1'b1, 1'b1)});
    chk("dr2_n b hi", dr2_n, 1'b1);
    chk("flags", {ff1_n, ff2_n, hf1_n, hf2_n}, 4'hf);
    report_and_stop();
  end
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    n_fail++;
    report_and_stop();
  end
endmodule
